// >>> inc/b4ec_map.svh
// Offsets, field positions and codes of the bank 4 error code encoder
`ifndef B4EC_MAP_SVH
`define B4EC_MAP_SVH
`define B4EC_LLC_WAYS 8
`define B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB 16
`define B4EC_LLC_FIXED 11'h100
`define B4EC_LLC_NONE 3'h0
`define B4EC_LLC_MULTI_CE 3'h1
`define B4EC_LLC_MULTI_UE 3'h2
`define B4EC_LLC_MULTI_HIT 3'h3
`define B4EC_LLC_ONE_CE 3'h5
`define B4EC_LLC_ONE_UE 3'h6
`define B4EC_LLC_MIXED 3'h7
`define B4EC_BUS_REQ_PAR 16
`define B4EC_BUS_C0_ADDR 17
`define B4EC_BUS_C1_ADDR 18
`define B4EC_BUS_RSP_PAR 20
`define B4EC_BUS_DATA_PAR 21
`define B4EC_BUS_C0_DATA 22
`define B4EC_BUS_C1_DATA 23
`define B4EC_BUS_DEFER 24
`define B4EC_BUS_ECC 25
`define B4EC_BUS_DSTB 26
`define B4EC_BUS_ASTB 27
`define B4EC_CBC_INCL_C0 16'h0001
`define B4EC_CBC_INCL_C1 16'h0002
`define B4EC_CBC_WREX_C0 16'h0003
`define B4EC_CBC_WREX_C1 16'h0004
`define B4EC_CBC_INCL_BUS 16'h0005
`define B4EC_CBC_SNP_STALL 16'h0006
`define B4EC_CBC_WR_STALL 16'h0007
`define B4EC_CBC_ARB_TMO 16'h0008
`define B4EC_CBC_OOQ 16'h0009
`define B4EC_CBC_THERM 16'h0100
`define B4EC_CBC_TMO_A 16'h0200
`define B4EC_CBC_TMO_B 16'h0300
`define B4EC_CBC_PROT_Q 16'h0400
`define B4EC_CBC_CE_BUS 16'hC001
`define B4EC_CBC_CE_C0 16'hC002
`define B4EC_CBC_CE_C1 16'hC004
`define B4EC_CBC_UE_BUS 16'hE001
`define B4EC_CBC_UE_C0 16'hE002
`define B4EC_CBC_UE_C1 16'hE004
`define B4EC_CBC_CE_TOP 3'h6
`define B4EC_LOW_LLC 16'h010B
`define B4EC_LOW_BUS 16'h0E0F
`define B4EC_LOW_CBC 16'h0400
`define B4EC_ST_VAL 63
`define B4EC_ST_UC 61
`define B4EC_ST_SYNV 52
`define B4EC_ST_SYN_LSB 44
`endif

// >>> inc/b4ec_pkg.sv
// Types shared by the bank 4 error code encoder
package b4ec_pkg;
    typedef struct packed {
        logic [7:0] ce_ways;
        logic [7:0] ue_ways;
        logic [7:0] hit_ways;
    } b4ec_llc_s;
    typedef struct packed {
        logic req_par;
        logic c0_addr_par;
        logic c1_addr_par;
        logic rsp_par;
        logic data_par;
        logic c0_data_par;
        logic c1_data_par;
        logic defer_par_a;
        logic defer_par_b;
        logic ecc;
        logic ecc_correctable;
        logic data_strobe_glitch;
        logic req_strobe_glitch;
        logic [7:0] syndrome;
    } b4ec_bus_s;
    typedef enum logic [4:0] {
        B4EC_C_INCL_C0 = 5'h00, B4EC_C_INCL_C1 = 5'h01, B4EC_C_WREX_C0 = 5'h02,
        B4EC_C_WREX_C1 = 5'h03, B4EC_C_INCL_BUS = 5'h04, B4EC_C_SNP_STALL = 5'h05,
        B4EC_C_WR_STALL = 5'h06, B4EC_C_ARB_TMO = 5'h07, B4EC_C_OOQ = 5'h08,
        B4EC_C_THERM = 5'h09, B4EC_C_TMO_A = 5'h0A, B4EC_C_TMO_B = 5'h0B,
        B4EC_C_PROT_Q = 5'h0C, B4EC_C_CE_BUS = 5'h0D, B4EC_C_CE_C0 = 5'h0E,
        B4EC_C_CE_C1 = 5'h0F, B4EC_C_UE_BUS = 5'h10, B4EC_C_UE_C0 = 5'h11,
        B4EC_C_UE_C1 = 5'h12
    } b4ec_cause_e;
    typedef struct packed {
        logic valid;
        b4ec_cause_e cause;
        logic syn_valid;
        logic [7:0] syndrome;
    } b4ec_cbc_s;
    typedef enum logic [1:0] {B4EC_IDLE = 2'h0, B4EC_LOGGED = 2'h1} b4ec_state_e;
    typedef struct packed {
        b4ec_state_e state;
        logic [63:0] status;
        logic [63:0] rd_data;
        logic rd_valid;
    } b4ec_regs_s;
    function automatic logic [3:0] b4ec_ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int k = 0; k < 8; k++) begin
            n = n + {3'h0, v[k]};
        end
        return n;
    endfunction
endpackage

// >>> src/b4ec_way_coder.sv
// Way report to last-level cache way code translator
`include "b4ec_map.svh"
module b4ec_way_coder (
    // Way reports
    input wire b4ec_pkg::b4ec_llc_s i_llc,
    // Way code
    output logic [2:0] o_code,
    output logic o_any
);
    logic [3:0] ce_n;
    logic [3:0] ue_n;
    logic [3:0] hit_n;
    always_comb begin
        ce_n = b4ec_pkg::b4ec_ones(i_llc.ce_ways);
        ue_n = b4ec_pkg::b4ec_ones(i_llc.ue_ways);
        hit_n = b4ec_pkg::b4ec_ones(i_llc.hit_ways);
        if (ce_n != 4'h0 && ue_n != 4'h0) begin
            o_code = `B4EC_LLC_MIXED;
        end else if (ue_n > 4'h1) begin
            o_code = `B4EC_LLC_MULTI_UE;
        end else if (ue_n == 4'h1) begin
            o_code = `B4EC_LLC_ONE_UE;
        end else if (hit_n > 4'h1) begin
            o_code = `B4EC_LLC_MULTI_HIT;
        end else if (ce_n > 4'h1) begin
            o_code = `B4EC_LLC_MULTI_CE;
        end else if (ce_n == 4'h1) begin
            o_code = `B4EC_LLC_ONE_CE;
        end else begin
            o_code = `B4EC_LLC_NONE;
        end
        o_any = (o_code != `B4EC_LLC_NONE);
    end
endmodule

// >>> src/b4ec_encoder.sv
// Bank 4 error status logger with model-specific error code encoding
`include "b4ec_map.svh"
module b4ec_encoder (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Error detections
    input wire b4ec_pkg::b4ec_llc_s i_llc,
    input wire b4ec_pkg::b4ec_bus_s i_bus,
    input wire b4ec_pkg::b4ec_cbc_s i_cbc,
    // Status register access
    input wire logic i_rd_en,
    input wire logic i_clear,
    output logic o_rd_valid,
    output logic [63:0] o_rd_data,
    output logic [63:0] o_status
);
    b4ec_pkg::b4ec_regs_s regs_r;
    b4ec_pkg::b4ec_regs_s regs_nxt;
    logic [2:0] llc_code;
    logic llc_any;
    logic bus_any;
    logic [15:0] bus_field;
    logic bus_uc;
    logic bus_syn;
    logic [15:0] cbc_field;
    logic cbc_ce;
    logic event_any;
    logic [63:0] new_status;

    b4ec_way_coder u_way_coder (
        .i_llc(i_llc),
        .o_code(llc_code),
        .o_any(llc_any)
    );

    // Raw bus detection bits placed at their field positions
    function automatic logic [15:0] bus_raw(input b4ec_pkg::b4ec_bus_s b);
        logic [15:0] r;
        r = 16'h0000;
        r[`B4EC_BUS_REQ_PAR - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] = b.req_par;
        r[`B4EC_BUS_RSP_PAR - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] = b.rsp_par;
        r[`B4EC_BUS_DATA_PAR - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] = b.data_par;
        r[`B4EC_BUS_C0_ADDR - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] = b.c0_addr_par;
        r[`B4EC_BUS_C1_ADDR - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] = b.c1_addr_par;
        r[`B4EC_BUS_C0_DATA - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] = b.c0_data_par;
        r[`B4EC_BUS_C1_DATA - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] = b.c1_data_par;
        r[`B4EC_BUS_DEFER - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] = b.defer_par_a | b.defer_par_b;
        r[`B4EC_BUS_ECC - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] = b.ecc;
        r[`B4EC_BUS_DSTB - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] = b.data_strobe_glitch;
        r[`B4EC_BUS_ASTB - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] = b.req_strobe_glitch;
        return r;
    endfunction

    // Controller cause to code
    function automatic logic [15:0] cbc_map(input b4ec_pkg::b4ec_cause_e c);
        logic [15:0] v;
        v = 16'h0000;
        case (c)
            b4ec_pkg::B4EC_C_INCL_C0: v = `B4EC_CBC_INCL_C0;
            b4ec_pkg::B4EC_C_INCL_C1: v = `B4EC_CBC_INCL_C1;
            b4ec_pkg::B4EC_C_INCL_BUS: v = `B4EC_CBC_INCL_BUS;
            b4ec_pkg::B4EC_C_WREX_C0: v = `B4EC_CBC_WREX_C0;
            b4ec_pkg::B4EC_C_WREX_C1: v = `B4EC_CBC_WREX_C1;
            b4ec_pkg::B4EC_C_SNP_STALL: v = `B4EC_CBC_SNP_STALL;
            b4ec_pkg::B4EC_C_WR_STALL: v = `B4EC_CBC_WR_STALL;
            b4ec_pkg::B4EC_C_ARB_TMO: v = `B4EC_CBC_ARB_TMO;
            b4ec_pkg::B4EC_C_OOQ: v = `B4EC_CBC_OOQ;
            b4ec_pkg::B4EC_C_THERM: v = `B4EC_CBC_THERM;
            b4ec_pkg::B4EC_C_TMO_A: v = `B4EC_CBC_TMO_A;
            b4ec_pkg::B4EC_C_TMO_B: v = `B4EC_CBC_TMO_B;
            b4ec_pkg::B4EC_C_PROT_Q: v = `B4EC_CBC_PROT_Q;
            b4ec_pkg::B4EC_C_CE_BUS: v = `B4EC_CBC_CE_BUS;
            b4ec_pkg::B4EC_C_CE_C0: v = `B4EC_CBC_CE_C0;
            b4ec_pkg::B4EC_C_CE_C1: v = `B4EC_CBC_CE_C1;
            b4ec_pkg::B4EC_C_UE_BUS: v = `B4EC_CBC_UE_BUS;
            b4ec_pkg::B4EC_C_UE_C0: v = `B4EC_CBC_UE_C0;
            b4ec_pkg::B4EC_C_UE_C1: v = `B4EC_CBC_UE_C1;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    always_comb begin
        bus_field = bus_raw(i_bus);
        bus_any = (bus_field != 16'h0000);
        bus_field = bus_field & (~bus_field + 16'h0001);
        // Only correctable inbound ECC clears the flag
        bus_syn = bus_field[`B4EC_BUS_ECC - `B4EC_MODEL_SPECIFIC_ERROR_CODE_LSB] & i_bus.ecc_correctable;
        bus_uc = ~bus_syn;
        cbc_field = cbc_map(i_cbc.cause);
        // Only correctable ECC codes are corrected
        cbc_ce = (cbc_field[15:13] == `B4EC_CBC_CE_TOP);
        event_any = llc_any | bus_any | (i_cbc.valid & (cbc_field != 16'h0000));
        new_status = 64'h0;
        new_status[`B4EC_ST_VAL] = 1'b1;
        // Class chosen by low code; cache first, then bus
        if (llc_any) begin
            new_status[15:0] = `B4EC_LOW_LLC;
            // Fixed pattern over zero reserved pair
            new_status[31:16] = {`B4EC_LLC_FIXED, 2'h0, llc_code};
            new_status[`B4EC_ST_UC] = (llc_code != `B4EC_LLC_MULTI_CE) && (llc_code != `B4EC_LLC_ONE_CE);
        end else if (bus_any) begin
            new_status[15:0] = `B4EC_LOW_BUS;
            new_status[31:16] = bus_field & 16'h0FF7;
            new_status[`B4EC_ST_UC] = bus_uc;
            if (bus_syn) begin
                new_status[`B4EC_ST_SYN_LSB +: 8] = i_bus.syndrome;
                new_status[`B4EC_ST_SYNV] = 1'b1;
            end
        end else begin
            new_status[15:0] = `B4EC_LOW_CBC;
            new_status[31:16] = cbc_field;
            new_status[`B4EC_ST_UC] = ~cbc_ce;
            if (cbc_ce && i_cbc.syn_valid) begin
                new_status[`B4EC_ST_SYN_LSB +: 8] = i_cbc.syndrome;
                new_status[`B4EC_ST_SYNV] = 1'b1;
            end
        end
    end

    always_comb begin
        regs_nxt = regs_r;
        regs_nxt.rd_valid = i_rd_en;
        if (i_rd_en) begin
            regs_nxt.rd_data = regs_r.status;
        end
        case (regs_r.state)
            b4ec_pkg::B4EC_IDLE: begin
                // Whole word loaded at one edge
                if (event_any) begin
                    regs_nxt.status = new_status;
                    regs_nxt.state = b4ec_pkg::B4EC_LOGGED;
                end
            end
            b4ec_pkg::B4EC_LOGGED: begin
                // New event beats a clear in the same cycle
                if (i_clear && event_any) begin
                    regs_nxt.status = new_status;
                end else if (i_clear) begin
                    regs_nxt.status = 64'h0;
                    regs_nxt.state = b4ec_pkg::B4EC_IDLE;
                end
            end
            default: begin
                regs_nxt.status = 64'h0;
                regs_nxt.state = b4ec_pkg::B4EC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            regs_r <= '0;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    assign o_status = regs_r.status;
    assign o_rd_data = regs_r.rd_data;
    assign o_rd_valid = regs_r.rd_valid;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    logic is_llc;
    logic is_bus;
    logic is_cbc;
    logic idle;
    assign is_llc = o_status[`B4EC_ST_VAL] && (o_status[15:0] == `B4EC_LOW_LLC);
    assign is_bus = o_status[`B4EC_ST_VAL] && (o_status[15:0] == `B4EC_LOW_BUS);
    assign is_cbc = o_status[`B4EC_ST_VAL] && (o_status[15:0] == `B4EC_LOW_CBC);
    assign idle = (regs_r.state == b4ec_pkg::B4EC_IDLE);
    // No bus cause below the defer bit, and no bus cause at all
    logic bus_low_quiet;
    logic bus_quiet;
    assign bus_low_quiet = !(i_bus.req_par || i_bus.c0_addr_par || i_bus.c1_addr_par || i_bus.rsp_par
        || i_bus.data_par || i_bus.c0_data_par || i_bus.c1_data_par);
    assign bus_quiet = bus_low_quiet && !(i_bus.defer_par_a || i_bus.defer_par_b || i_bus.ecc
        || i_bus.data_strobe_glitch || i_bus.req_strobe_glitch);

    property p_llc_fixed;
        is_llc |-> (o_status[31:21] == `B4EC_LLC_FIXED) && (o_status[20:19] == 2'h0)
            && (o_status[18:16] != `B4EC_LLC_NONE) && (o_status[18:16] != 3'h4);
    endproperty
    a_llc_fixed: assert property (p_llc_fixed) else $error("cache fixed pattern wrong");

    property p_llc_mixed;
        (idle && i_llc.ce_ways != 8'h00 && i_llc.ue_ways != 8'h00)
            |=> is_llc && (o_status[18:16] == `B4EC_LLC_MIXED);
    endproperty
    a_llc_mixed: assert property (p_llc_mixed) else $error("mixed way code missing");

    property p_llc_multi_ce;
        (idle && b4ec_pkg::b4ec_ones(i_llc.ce_ways) > 4'h1 && i_llc.ue_ways == 8'h00
            && b4ec_pkg::b4ec_ones(i_llc.hit_ways) < 4'h2)
            |=> (o_status[18:16] == `B4EC_LLC_MULTI_CE) && !o_status[`B4EC_ST_UC];
    endproperty
    a_llc_multi_ce: assert property (p_llc_multi_ce) else $error("multi-way correctable code wrong");

    property p_bus_onehot;
        is_bus |-> $onehot(o_status[31:16]) && (o_status[31:28] == 4'h0) && !o_status[19];
    endproperty
    a_bus_onehot: assert property (p_bus_onehot) else $error("bus code not one-hot");

    property p_bus_uc;
        is_bus && !o_status[`B4EC_BUS_ECC] |-> o_status[`B4EC_ST_UC];
    endproperty
    a_bus_uc: assert property (p_bus_uc) else $error("bus error not uncorrected");

    property p_bus_req;
        (idle && i_llc == '0 && i_bus.req_par) |=> is_bus && o_status[`B4EC_BUS_REQ_PAR];
    endproperty
    a_bus_req: assert property (p_bus_req) else $error("request parity not logged");

    property p_cbc_uc;
        is_cbc |-> (o_status[`B4EC_ST_UC] == (o_status[31:29] != `B4EC_CBC_CE_TOP));
    endproperty
    a_cbc_uc: assert property (p_cbc_uc) else $error("controller correction flag wrong");

    property p_syn_valid;
        o_status[`B4EC_ST_SYNV] |-> !o_status[`B4EC_ST_UC] && o_status[`B4EC_ST_VAL];
    endproperty
    a_syn_valid: assert property (p_syn_valid) else $error("syndrome on uncorrected error");

    property p_hold;
        (!idle && !i_clear) |=> $stable(o_status);
    endproperty
    a_hold: assert property (p_hold) else $error("logged status changed");

    property p_read;
        i_rd_en |=> o_rd_valid && (o_rd_data == $past(o_status));
    endproperty
    a_read: assert property (p_read) else $error("read data mismatch");

    property p_llc_one_ce;
        (idle && b4ec_pkg::b4ec_ones(i_llc.ce_ways) == 4'h1 && i_llc.ue_ways == 8'h00
            && b4ec_pkg::b4ec_ones(i_llc.hit_ways) < 4'h2) |=> is_llc && (o_status[18:16] == `B4EC_LLC_ONE_CE);
    endproperty
    a_llc_one_ce: assert property (p_llc_one_ce) else $error("single-way correctable code wrong");

    property p_llc_one_ue;
        (idle && i_llc.ce_ways == 8'h00 && b4ec_pkg::b4ec_ones(i_llc.ue_ways) == 4'h1)
            |=> is_llc && (o_status[18:16] == `B4EC_LLC_ONE_UE) && o_status[`B4EC_ST_UC];
    endproperty
    a_llc_one_ue: assert property (p_llc_one_ue) else $error("single-way uncorrectable code wrong");

    property p_llc_multi_ue;
        (idle && i_llc.ce_ways == 8'h00 && b4ec_pkg::b4ec_ones(i_llc.ue_ways) > 4'h1)
            |=> is_llc && (o_status[18:16] == `B4EC_LLC_MULTI_UE) && o_status[`B4EC_ST_UC];
    endproperty
    a_llc_multi_ue: assert property (p_llc_multi_ue) else $error("multi-way uncorrectable code wrong");

    property p_llc_multi_hit;
        (idle && i_llc.ce_ways == 8'h00 && i_llc.ue_ways == 8'h00 && b4ec_pkg::b4ec_ones(i_llc.hit_ways) > 4'h1)
            |=> is_llc && (o_status[18:16] == `B4EC_LLC_MULTI_HIT);
    endproperty
    a_llc_multi_hit: assert property (p_llc_multi_hit) else $error("multi-way tag hit code wrong");

    property p_bus_defer;
        (idle && i_llc == '0 && bus_low_quiet && (i_bus.defer_par_a || i_bus.defer_par_b))
            |=> is_bus && o_status[`B4EC_BUS_DEFER] && o_status[`B4EC_ST_UC];
    endproperty
    a_bus_defer: assert property (p_bus_defer) else $error("defer parity not on its bit");

    property p_bus_ecc_ce;
        (idle && i_llc == '0 && bus_low_quiet && !i_bus.defer_par_a && !i_bus.defer_par_b && i_bus.ecc
            && i_bus.ecc_correctable) |=> is_bus && o_status[`B4EC_BUS_ECC] && !o_status[`B4EC_ST_UC]
            && o_status[`B4EC_ST_SYNV] && (o_status[`B4EC_ST_SYN_LSB +: 8] == $past(i_bus.syndrome));
    endproperty
    a_bus_ecc_ce: assert property (p_bus_ecc_ce) else $error("correctable inbound ECC logged wrong");

    property p_bus_syn;
        is_bus && o_status[`B4EC_ST_SYNV] |-> o_status[`B4EC_BUS_ECC];
    endproperty
    a_bus_syn: assert property (p_bus_syn) else $error("bus syndrome without ECC cause");

    property p_cbc_legal;
        is_cbc |-> o_status[31:16] inside {`B4EC_CBC_INCL_C0, `B4EC_CBC_INCL_C1, `B4EC_CBC_WREX_C0,
            `B4EC_CBC_WREX_C1, `B4EC_CBC_INCL_BUS, `B4EC_CBC_SNP_STALL, `B4EC_CBC_WR_STALL,
            `B4EC_CBC_ARB_TMO, `B4EC_CBC_OOQ, `B4EC_CBC_THERM, `B4EC_CBC_TMO_A, `B4EC_CBC_TMO_B,
            `B4EC_CBC_PROT_Q, `B4EC_CBC_CE_BUS, `B4EC_CBC_CE_C0, `B4EC_CBC_CE_C1, `B4EC_CBC_UE_BUS,
            `B4EC_CBC_UE_C0, `B4EC_CBC_UE_C1};
    endproperty
    a_cbc_legal: assert property (p_cbc_legal) else $error("controller code not defined");

    property p_cbc_ooq;
        (idle && i_llc == '0 && bus_quiet && i_cbc.valid && i_cbc.cause == b4ec_pkg::B4EC_C_OOQ)
            |=> is_cbc && (o_status[31:16] == `B4EC_CBC_OOQ) && o_status[`B4EC_ST_UC];
    endproperty
    a_cbc_ooq: assert property (p_cbc_ooq) else $error("queue fault code wrong");

    property p_cbc_tmo;
        (idle && i_llc == '0 && bus_quiet && i_cbc.valid && i_cbc.cause == b4ec_pkg::B4EC_C_TMO_B)
            |=> is_cbc && (o_status[31:16] == `B4EC_CBC_TMO_B) && o_status[`B4EC_ST_UC];
    endproperty
    a_cbc_tmo: assert property (p_cbc_tmo) else $error("internal timeout code wrong");

    property p_cbc_prot;
        (idle && i_llc == '0 && bus_quiet && i_cbc.valid && i_cbc.cause == b4ec_pkg::B4EC_C_PROT_Q)
            |=> is_cbc && (o_status[31:16] == `B4EC_CBC_PROT_Q) && o_status[`B4EC_ST_UC];
    endproperty
    a_cbc_prot: assert property (p_cbc_prot) else $error("protection queue code wrong");

    property p_cbc_ce;
        (idle && i_llc == '0 && bus_quiet && i_cbc.valid && i_cbc.syn_valid
            && i_cbc.cause == b4ec_pkg::B4EC_C_CE_BUS) |=> is_cbc && (o_status[31:16] == `B4EC_CBC_CE_BUS)
            && !o_status[`B4EC_ST_UC] && o_status[`B4EC_ST_SYNV]
            && (o_status[`B4EC_ST_SYN_LSB +: 8] == $past(i_cbc.syndrome));
    endproperty
    a_cbc_ce: assert property (p_cbc_ce) else $error("outgoing correctable ECC logged wrong");

    property p_cbc_ue;
        (idle && i_llc == '0 && bus_quiet && i_cbc.valid && i_cbc.cause == b4ec_pkg::B4EC_C_UE_C1)
            |=> is_cbc && (o_status[31:16] == `B4EC_CBC_UE_C1) && o_status[`B4EC_ST_UC] && !o_status[`B4EC_ST_SYNV];
    endproperty
    a_cbc_ue: assert property (p_cbc_ue) else $error("outgoing uncorrectable ECC logged wrong");

    property p_set_wins;
        (!idle && i_clear && i_llc == '0 && bus_quiet && i_cbc.valid && i_cbc.cause == b4ec_pkg::B4EC_C_UE_C1)
            |=> is_cbc && (o_status[31:16] == `B4EC_CBC_UE_C1);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to coincident clear");

    property p_clear;
        (!idle && i_clear && i_llc == '0 && bus_quiet && !i_cbc.valid) |=> idle && (o_status == 64'h0);
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared");

    property p_rd_idle;
        !i_rd_en |=> !o_rd_valid;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read valid without request");

    c_llc: cover property (idle ##1 is_llc);
    c_bus_syn: cover property (is_bus && o_status[`B4EC_ST_SYNV]);
    c_cbc: cover property (idle ##1 is_cbc);
    c_clear_event: cover property (!idle && i_clear && event_any);
    c_rd_logged: cover property (o_rd_valid && o_rd_data[`B4EC_ST_VAL]);
endmodule

// >>> bench/b4ec_far_side.sv
// Far-side model: cores and system bus presenting one-cycle error detections
module b4ec_far_side (
    // Clock
    input wire logic i_core_clk,
    // Command from the bench
    input wire logic i_fire,
    input wire b4ec_pkg::b4ec_llc_s i_llc_v,
    input wire b4ec_pkg::b4ec_bus_s i_bus_v,
    input wire b4ec_pkg::b4ec_cbc_s i_cbc_v,
    // Detections toward the encoder
    output b4ec_pkg::b4ec_llc_s o_llc,
    output b4ec_pkg::b4ec_bus_s o_bus,
    output b4ec_pkg::b4ec_cbc_s o_cbc
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_llc = '0;
        o_bus = '0;
        o_cbc = '0;
    end
    // Between events the syndromes churn, so only qualified ones may be logged
    always @(posedge i_core_clk) begin
        if (i_fire) begin
            o_llc <= i_llc_v;
            o_bus <= i_bus_v;
            o_cbc <= i_cbc_v;
        end else begin
            o_llc <= '0;
            o_bus <= {13'h0000, ~o_bus.syndrome};
            o_cbc <= {7'h00, ~o_cbc.syndrome};
        end
    end
endmodule

// >>> bench/bank4_error_code_encoder_test.sv
// Self-checking bench for the bank 4 error code encoder
module bank4_error_code_encoder_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_core_clk;
    logic i_rstn;
    logic fire;
    logic rd_en;
    logic clear;
    b4ec_pkg::b4ec_llc_s llc_v;
    b4ec_pkg::b4ec_bus_s bus_v;
    b4ec_pkg::b4ec_cbc_s cbc_v;
    b4ec_pkg::b4ec_llc_s llc;
    b4ec_pkg::b4ec_bus_s bus;
    b4ec_pkg::b4ec_cbc_s cbc;
    logic rd_valid;
    logic [63:0] rd_data;
    logic [63:0] status;
    logic [63:0] w;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [23:0] lv [6] = '{24'h010000, 24'h810000, 24'h000200, 24'h000600, 24'h000030, 24'h010200};
    logic [2:0] lc [6] = '{3'h5, 3'h1, 3'h6, 3'h2, 3'h3, 3'h7};
    int pos [13] = '{16, 17, 18, 20, 21, 22, 23, 24, 24, 25, 0, 26, 27};
    logic [15:0] cc [19] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007,
        16'h0008, 16'h0009, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'hC001, 16'hC002, 16'hC004,
        16'hE001, 16'hE002, 16'hE004};

    always #5 i_core_clk = ~i_core_clk;

    b4ec_far_side b4ec_far_side_inst (
        .i_core_clk(i_core_clk), .i_fire(fire), .i_llc_v(llc_v), .i_bus_v(bus_v), .i_cbc_v(cbc_v),
        .o_llc(llc), .o_bus(bus), .o_cbc(cbc)
    );
    b4ec_encoder b4ec_encoder_inst (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_llc(llc), .i_bus(bus), .i_cbc(cbc),
        .i_rd_en(rd_en), .i_clear(clear), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_status(status)
    );

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Logged word: valid, uncorrected, syndrome with its valid flag, code, class
    function automatic logic [63:0] word(input logic uc, input logic [15:0] code, input logic [15:0] low,
        input logic [8:0] syn);
        return {1'b1, 1'b0, uc, 8'h00, syn, 12'h000, code, low};
    endfunction

    // Present detections for one cycle; optional clear taken on the same edge
    task automatic inject(input b4ec_pkg::b4ec_llc_s l, input b4ec_pkg::b4ec_bus_s b,
        input b4ec_pkg::b4ec_cbc_s c, input logic clr);
        @(posedge i_core_clk);
        fire <= 1'b1;
        llc_v <= l;
        bus_v <= b;
        cbc_v <= c;
        @(posedge i_core_clk);
        fire <= 1'b0;
        clear <= clr;
        @(posedge i_core_clk);
        clear <= 1'b0;
        #1;
    endtask

    task automatic run(input b4ec_pkg::b4ec_llc_s l, input b4ec_pkg::b4ec_bus_s b,
        input b4ec_pkg::b4ec_cbc_s c, input logic [63:0] exp);
        inject(l, b, c, 1'b0);
        chk(status, exp);
        inject('0, '0, '0, 1'b1);
        chk(status, 64'h0);
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100us;
        n_mismatch++;
        conclude();
    end

    initial begin
        i_core_clk = 1'b0;
        i_rstn = 1'b0;
        fire = 1'b0;
        rd_en = 1'b0;
        clear = 1'b0;
        llc_v = '0;
        bus_v = '0;
        cbc_v = '0;
        repeat (12) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        #1;
        chk(status, 64'h0);
        chk({63'h0, rd_valid}, 64'h0);
        for (int k = 0; k < 6; k++) begin
            w = word(lc[k] != 3'h1 && lc[k] != 3'h5, {11'h100, 2'b00, lc[k]}, 16'h010B, 9'h000);
            run(lv[k], '0, '0, w);
        end
        inject(24'h000004, '0, '0, 1'b0);
        chk(status, 64'h0);
        // one bus cause at a time
        for (int k = 0; k < 13; k++) begin
            if (k != 10) begin
                w = word(1'b1, 16'h0001 << (pos[k] - 16), 16'h0E0F, 9'h000);
                run('0, {13'h1000 >> k, 8'h5A}, '0, w);
            end
        end
        run('0, {13'h000C, 8'h5A}, '0, word(1'b0, 16'h0200, 16'h0E0F, 9'h15A));
        run('0, {13'h1001, 8'h5A}, '0, word(1'b1, 16'h0001, 16'h0E0F, 9'h000));
        run('0, {13'h0030, 8'h5A}, '0, word(1'b1, 16'h0100, 16'h0E0F, 9'h000));
        for (int k = 0; k < 19; k++) begin
            w = word(!(k >= 13 && k <= 15), cc[k], 16'h0400, (k >= 13 && k <= 15) ? 9'h1C3 : 9'h000);
            run('0, '0, {1'b1, k[4:0], 1'b1, 8'hC3}, w);
        end
        run('0, '0, {1'b1, 5'h0E, 1'b0, 8'hC3}, word(1'b0, 16'hC002, 16'h0400, 9'h000));
        w = word(1'b0, 16'h2005, 16'h010B, 9'h000);
        run(24'h010000, {13'h1000, 8'h00}, {1'b1, 5'h00, 1'b0, 8'h00}, w);
        run('0, {13'h0001, 8'h00}, {1'b1, 5'h00, 1'b0, 8'h00}, word(1'b1, 16'h0800, 16'h0E0F, 9'h000));
        // first error kept, coincident event beats clear
        inject('0, {13'h1000, 8'h00}, '0, 1'b0);
        inject('0, '0, {1'b1, 5'h07, 1'b0, 8'h00}, 1'b0);
        chk(status, word(1'b1, 16'h0001, 16'h0E0F, 9'h000));
        inject('0, '0, {1'b1, 5'h12, 1'b0, 8'h00}, 1'b1);
        w = word(1'b1, 16'hE004, 16'h0400, 9'h000);
        chk(status, w);
        @(posedge i_core_clk);
        rd_en <= 1'b1;
        clear <= 1'b1;
        @(posedge i_core_clk);
        clear <= 1'b0;
        #1;
        chk({63'h0, rd_valid}, 64'h1);
        chk(rd_data, w);
        @(posedge i_core_clk);
        rd_en <= 1'b0;
        #1;
        chk({63'h0, rd_valid}, 64'h1);
        chk(rd_data, 64'h0);
        @(posedge i_core_clk);
        #1;
        chk({63'h0, rd_valid}, 64'h0);
        chk(status, 64'h0);
        // Reset in mid-run drops a logged error, logging resumes after it
        inject('0, {13'h1000, 8'h00}, '0, 1'b0);
        @(posedge i_core_clk);
        i_rstn <= 1'b0;
        @(posedge i_core_clk);
        #1;
        chk(status, 64'h0);
        @(posedge i_core_clk);
        i_rstn <= 1'b1;
        inject('0, {13'h0010, 8'h00}, '0, 1'b0);
        chk(status, word(1'b1, 16'h0100, 16'h0E0F, 9'h000));
        inject('0, '0, '0, 1'b1);
        chk(status, 64'h0);
        conclude();
    end
endmodule
